// [conv_ctrl.v]
`timescale 1ns/1ps
`default_nettype none
`include "conv_ctrl_map.vh"
module conv_ctrl
// Cycle counts are parameters so a test can shorten them
#(
	parameter SHORT_CYC = `CTIME_SHORT_MS * 1000 * `CLK_MHZ,  // 100 ms in cycles
	parameter LONG_CYC  = `CTIME_LONG_MS * 1000 * `CLK_MHZ,   // 800 ms in cycles
	parameter TW        = 28
)
(
	// Clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// Front end measurement, from outside the clock domain
	input  wire [11:0] light_level,
	input  wire        light_over,
	// Status outputs, each from a flip-flop
	output reg         irq,
	output reg  [3:0]  result_exponent,
	output reg         conv_busy,
	output reg  [2:0]  resolution_loss
);
	// Control fields
	reg [3:0]  range_select_ff;   // Programmed range or auto code
	reg        conv_time_sel_ff;  // Short or long conversion
	reg [1:0]  conv_mode_ff;      // Shutdown, single or continuous
	reg        overflow_flag_ff;  // Last conversion overflowed
	reg        conv_done_flag_ff; // Conversion completed since last control read or starting write
	// Result fields
	reg [3:0]  active_range_ff;   // Range used by current conversion
	reg [11:0] mantissa_ff;       // Latest result mantissa
	reg [`IRQ_W-1:0] irq_stat_ff; // Sticky events
	reg [`IRQ_W-1:0] irq_mask_ff; // Enables
	// Bus address phase capture
	// A write's target is held here until its data phase
	reg        wr_pend_ff;
	// Address of the pending write
	reg [7:0]  addr_ff;
	// Measurement input synchroniser, three stages
	// Stage one may go metastable; nothing but stage two reads it
	reg [12:0] meas_s1_ff;
	reg [12:0] meas_s2_ff;
	reg [12:0] meas_s3_ff;
	reg [12:0] meas_ff;           // Accepted value once stages two and three agree

	// Decode of bus and timer events
	// Timer handshake back from the conversion counter
	wire        t_done;
	wire        t_busy;
	// Address phase accepted; hsize is ignored, every register is one word
	wire        addr_ok   = hsel & hready & htrans[1];
	// Read accepted in this address phase
	wire        rd_now    = addr_ok & ~hwrite;
	// Control write lands in its data phase, when hwdata stands
	wire        ctl_wr    = wr_pend_ff & (addr_ff == `ADDR_CONTROL);
	// Reads clear in the address phase, after the mux has been sampled
	wire        ctl_rd    = rd_now & (haddr == `ADDR_CONTROL);
	wire        st_rd     = rd_now & (haddr == `ADDR_IRQ_STATUS);
	// Fields of the word being written
	wire [1:0]  new_mode  = hwdata[`MODE_HI:`MODE_LO];
	wire [3:0]  new_range = hwdata[`RANGE_HI:`RANGE_LO];
	// Any mode but shutdown asks for a conversion
	wire        new_conv  = new_mode != `MODE_SHUTDOWN;
	// Overflow bit travels with the mantissa through the synchroniser
	wire        meas_over = meas_ff[12];
	// Range chosen by hardware rather than by the host
	wire        auto_mode = range_select_ff == `RANGE_AUTO;
	// Overflow in auto mode below top range forces a step up
	wire        step_up   = t_done & auto_mode & meas_over & (active_range_ff != `RANGE_MAX);
	// A done pulse that does not step up ends the conversion
	wire        finish    = t_done & ~step_up;
	// Single-shot mode returns to shutdown at its finish
	wire        single    = conv_mode_ff == `MODE_SINGLE;
	// Continuous mode re-arms on each finish; single mode does not
	wire        rearm     = finish & conv_mode_ff[1];
	// Any of the three reasons reloads the timer
	wire        t_start   = (ctl_wr & new_conv) | step_up | rearm;
	// Only a shutdown write stops the timer without a restart
	wire        t_stop    = ctl_wr & ~new_conv;
	// Length of a rearm or step comes from the stored time bit
	wire [TW-1:0] len     = conv_time_sel_ff ? LONG_CYC[TW-1:0] : SHORT_CYC[TW-1:0];
	// A write takes its length from the word being written
	wire [TW-1:0] len_w   = hwdata[`CTIME_BIT] ? LONG_CYC[TW-1:0] : SHORT_CYC[TW-1:0];
	// Control word as read back; low bits are not implemented here
	wire [15:0] ctl_word  = {range_select_ff, conv_time_sel_ff, conv_mode_ff,
	                         overflow_flag_ff, conv_done_flag_ff, 7'h00};
	// Events: abort, overflow at finish, finish
	wire [`IRQ_W-1:0] ev  = {ctl_wr & t_busy, finish & meas_over, finish};
	// Combinational next values
	reg  [2:0]  nxt_loss;
	reg  [31:0] nxt_rdata;

	// One timer serves every conversion; a write passes its own length
	conv_timer #(.W(TW)) u_timer
	(
		.hclk    (hclk),
		.hresetn (hresetn),
		.start   (t_start),
		.stop    (t_stop),
		.length  (ctl_wr ? len_w : len),
		.done_ff (t_done),
		.busy_ff (t_busy)
	);

	// Synchroniser; only stage two and three feed the comparison
	// Value moves only once two stages agree, so a word caught
	// mid-change is never taken
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			// All stages clear so no false change follows reset
			meas_s1_ff <= 13'h0000;
			meas_s2_ff <= 13'h0000;
			meas_s3_ff <= 13'h0000;
			meas_ff    <= 13'h0000;
		end
		else
		begin
			// Light and overflow sampled as one word
			meas_s1_ff <= {light_over, light_level};
			meas_s2_ff <= meas_s1_ff;
			meas_s3_ff <= meas_s2_ff;
			// A word still settling is held off for another cycle
			if (meas_s2_ff == meas_s3_ff)
				meas_ff <= meas_s3_ff;
		end
	end

	// Resolution loss for short conversions on low ranges
	// Loss is reported, not applied; the mantissa is never truncated
	always @*
	begin
		// Default: no loss
		nxt_loss = 3'h0;
		// Long conversions always keep full resolution
		if (!conv_time_sel_ff)
		begin
			// Lowest range loses the most
			if (active_range_ff == `LOSS3_RANGE)
				nxt_loss = 3'h3;
			// Ranges one to four lose two bits
			else if (active_range_ff < `LOSS1_RANGE)
				nxt_loss = 3'h2;
			// Range five loses one bit, higher ranges none
			else if (active_range_ff == `LOSS1_RANGE)
				nxt_loss = 3'h1;
		end
	end

	// Read mux for the data phase
	// Status read data is captured before the clear lands
	always @*
	begin
		// Only registered values feed the mux
		case (haddr)
			`ADDR_RESULT:     nxt_rdata = {16'h0000, active_range_ff, mantissa_ff};
			`ADDR_CONTROL:    nxt_rdata = {16'h0000, ctl_word};
			`ADDR_IRQ_STATUS: nxt_rdata = {{(32-`IRQ_W){1'b0}}, irq_stat_ff};
			`ADDR_IRQ_MASK:   nxt_rdata = {{(32-`IRQ_W){1'b0}}, irq_mask_ff};
			default:          nxt_rdata = 32'h00000000;
		endcase
	end

	// Bus slave: zero wait states, always OKAY
	// A slave that never stretches keeps the master simple
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			// Ready and OKAY never change
			wr_pend_ff <= 1'b0;
			addr_ff    <= 8'h00;
			hrdata     <= 32'h00000000;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
		end
		else
		begin
			// Remember a write until its data phase
			wr_pend_ff <= addr_ok & hwrite;
			// Address only moves when a transfer is taken
			if (addr_ok)
				addr_ff <= haddr;
			// Read data is launched for the data phase
			if (rd_now)
				hrdata <= nxt_rdata;
		end
	end

	// Control register and conversion sequencing
	// Auto mode restarts at range zero on every write; this costs
	// settling time in bright light but keeps one ranging path
	// Reserved codes, if written anyway, act as manual ranges
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			// Control word comes up as auto range, long time, shutdown
			range_select_ff   <= `RANGE_AUTO;
			conv_time_sel_ff  <= `CTIME_RESET;
			conv_mode_ff      <= `MODE_SHUTDOWN;
			// Flags and result clear with the control word
			overflow_flag_ff  <= 1'b0;
			conv_done_flag_ff <= 1'b0;
			active_range_ff   <= 4'h0;
			mantissa_ff       <= 12'h000;
			irq_mask_ff       <= {`IRQ_W{1'b0}};
		end
		else
		begin
			// A control write wins over a step or a finish in the same cycle
			if (ctl_wr)
			begin
				// Reserved range codes are stored as written; host keeps away
				range_select_ff  <= new_range;
				conv_time_sel_ff <= hwdata[`CTIME_BIT];
				conv_mode_ff     <= new_mode;
				// Auto mode starts at the lowest range and climbs
				active_range_ff  <= (new_range == `RANGE_AUTO) ? 4'h0 : new_range;
			end
			// Auto ranging step: range climbs by one
			else if (step_up)
				active_range_ff <= active_range_ff + 4'h1;
			// Single shot ends in shutdown
			else if (finish & single)
				conv_mode_ff <= `MODE_SHUTDOWN;
			// Mask write in its data phase
			if (wr_pend_ff & (addr_ff == `ADDR_IRQ_MASK))
				irq_mask_ff <= hwdata[`IRQ_W-1:0];
			// A write in the finishing cycle aborts, so no result
			if (finish & ~ctl_wr)
			begin
				mantissa_ff      <= meas_over ? `MANT_FULL : meas_ff[11:0];
				overflow_flag_ff <= meas_over;
			end
			// Set wins over a clearing read; a control write in the same cycle blocks the set
			if (finish & ~ctl_wr)
				conv_done_flag_ff <= 1'b1;
			else if (ctl_rd | (ctl_wr & new_conv))
				conv_done_flag_ff <= 1'b0;
		end
	end

	// Interrupt status: read clears, new events win
	// Flags and outputs share one process so all leave reset together
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			// Outputs quiet during reset
			irq_stat_ff     <= {`IRQ_W{1'b0}};
			irq             <= 1'b0;
			result_exponent <= 4'h0;
			conv_busy       <= 1'b0;
			resolution_loss <= 3'h0;
		end
		else
		begin
			// A read clears, an event in the same cycle still sets
			irq_stat_ff     <= (st_rd ? {`IRQ_W{1'b0}} : irq_stat_ff) | ev;
			// Interrupt level follows the masked status one cycle later
			irq             <= |(irq_stat_ff & irq_mask_ff);
			// Exponent shows the range in use
			result_exponent <= active_range_ff;
			// Busy mirrors the timer
			conv_busy       <= t_busy;
			// Loss follows the range in use
			resolution_loss <= nxt_loss;
		end
	end
endmodule
`default_nettype wire

// [conv_ctrl_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl_asserts (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [7:0]  haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        irq,
	input wire logic [3:0]  result_exponent,
	input wire logic        conv_busy,
	input wire logic [2:0]  resolution_loss
);
	logic       wr_ff;  // Control write in data phase
	logic [3:0] rng_ff; // Range of last control write
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Mark the data phase of a control write
	always @(posedge hclk or negedge hresetn)
		if (!hresetn)
			wr_ff <= 1'b0;
		else
			wr_ff <= hsel && hready && htrans[1] && hwrite && haddr == 8'h04;
	// Keep the range; no reset needed, read only after a write
	always @(posedge hclk)
		if (wr_ff)
			rng_ff <= hwdata[15:12];
	AST_BUS_OKAY: assert property (hreadyout && !hresp) else $error("bus not okay");
	AST_HIGH_HALF: assert property (hrdata[31:16] == 16'h0000) else $error("upper half set");
	AST_RESET_QUIET: assert property ($rose(hresetn) |-> !conv_busy && !irq && result_exponent == 4'h0)
		else $error("not quiet after reset");
	AST_SHUT_STOPS: assert property (wr_ff && hwdata[10:9] == 2'h0 |-> ##[1:3] !conv_busy)
		else $error("shutdown kept converting");
	AST_WRITE_STARTS: assert property (wr_ff && hwdata[10:9] != 2'h0 |-> ##[1:4] conv_busy)
		else $error("no conversion started");
	AST_RANGE_EXP: assert property (wr_ff && hwdata[10:9] != 2'h0 && hwdata[15:12] < 4'hC
		|-> ##[1:4] result_exponent == rng_ff) else $error("exponent not range");
	AST_LOSS_CAP: assert property (resolution_loss <= 3'h3) else $error("loss above three");
	AST_LOSS_NONE: assert property (result_exponent > 4'h5 [*3] |-> resolution_loss == 3'h0)
		else $error("loss on high range");
	cover property (wr_ff && hwdata[10:9] == 2'h1);
	cover property ($fell(conv_busy));
	cover property (irq);
endmodule
bind conv_ctrl conv_ctrl_asserts chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
	.hrdata, .hreadyout, .hresp, .irq, .result_exponent, .conv_busy, .resolution_loss);
`default_nettype wire

// [conv_ctrl_map.vh]
`ifndef CONV_CTRL_MAP_VH
`define CONV_CTRL_MAP_VH
// Byte addresses on the register bus (word aligned)
`define ADDR_RESULT        8'h00
`define ADDR_CONTROL       8'h04
`define ADDR_IRQ_STATUS    8'h08
`define ADDR_IRQ_MASK      8'h0C
`define ADDR_MEAS_INPUT    8'h10
// Field positions of the control word
`define RANGE_HI           15
`define RANGE_LO           12
`define CTIME_BIT          11
`define MODE_HI            10
`define MODE_LO            9
`define OVF_BIT            8
`define DONE_BIT           7
// Reset values and codes
`define RANGE_AUTO         4'hC
`define RANGE_MAX          4'hB
`define CTIME_RESET        1'h1
`define MODE_SHUTDOWN      2'h0
`define MODE_SINGLE        2'h1
// Conversion times in milliseconds
`define CTIME_SHORT_MS     100
`define CTIME_LONG_MS      800
`define CLK_MHZ            200
// Resolution loss thresholds for the short conversion
`define LOSS1_RANGE        4'h5
`define LOSS3_RANGE        4'h0
// Interrupt status bits
`define IRQ_DONE           0
`define IRQ_OVF            1
`define IRQ_ABORT          2
`define IRQ_W              3
`define MANT_FULL          12'hFFF
`endif

// [conv_timer.v]
`timescale 1ns/1ps
`default_nettype none
// Counts one conversion; restart reloads, expiry gives a one-cycle pulse
module conv_timer
#(
	parameter W = 28
)
(
	input  wire         hclk,
	input  wire         hresetn,
	input  wire         start,
	input  wire         stop,
	input  wire [W-1:0] length,
	output reg          done_ff,
	output reg          busy_ff
);
	reg [W-1:0] cnt_ff;   // Cycles left in the current conversion

	// Start wins over stop so an abort-and-restart in one cycle just reloads
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt_ff  <= {W{1'b0}};
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end
		else
		begin
			done_ff <= 1'b0;
			if (start)
			begin
				cnt_ff  <= length;
				busy_ff <= 1'b1;
			end
			else if (stop)
				busy_ff <= 1'b0;
			else if (busy_ff)
			begin
				if (cnt_ff == {{(W-1){1'b0}}, 1'b1})
				begin
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
				end
				cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule
`default_nettype wire

// [light_front.sv]
`timescale 1ns/1ps
`default_nettype none
// Front end: light scaled onto the range now in use
module light_front (
	input  wire logic        hclk,
	input  wire logic [23:0] lux,
	input  wire logic [3:0]  exp_in,
	output logic      [11:0] light_level,
	output logic             light_over
);
	wire [23:0] scaled = lux >> exp_in; // Light in steps of this range
	// Saturate and flag when the range is too small
	always @(posedge hclk)
	begin
		light_over <= scaled > 24'h000FFF;
		light_level <= scaled > 24'h000FFF ? 12'hFFF : scaled[11:0];
	end
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, conv_busy, light_over, ct;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize, resolution_loss;
	logic [31:0] hwdata, hrdata, q, t;
	logic [11:0] light_level;
	logic [3:0]  result_exponent;
	logic [23:0] lux;
	logic [15:0] res;
	integer      err_total = 0, total_checks = 0, r, n, m;
	// Short conversions keep the run brief
	conv_ctrl #(.SHORT_CYC(20), .LONG_CYC(160)) dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .light_level, .light_over, .irq,
		.result_exponent, .conv_busy, .resolution_loss);
	light_front fe_u (.hclk, .lux, .exp_in(result_exponent), .light_level, .light_over);
	initial
	begin
		hclk = 0;
		forever #2.5 hclk = ~hclk;
	end
	task chk(input [31:0] seen, input [31:0] want);
		total_checks++;
		if (seen !== want)
		begin
			err_total++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task summarize;
		if (err_total == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task rdy;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
	endtask
	// One transfer; read data taken at the closing edge
	task xfer(input [7:0] a, input w, input [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		rdy;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
		q = hrdata;
	endtask
	// Auto ranging climbs from range 0 while overflowing
	function automatic [15:0] expect_res(input [23:0] l, input [3:0] rr);
		integer e;
		e = (rr == 4'hC) ? 0 : rr;
		while (rr == 4'hC && e < 11 && (l >> e) > 24'hFFF)
			e++;
		expect_res = {e[3:0], (l >> e) > 24'hFFF ? 12'hFFF : l[e +: 12]};
	endfunction
	function automatic [2:0] loss_of(input [3:0] rr, input c);
		loss_of = c ? 3'h0 : rr == 4'h0 ? 3'h3 : rr < 4'h5 ? 3'h2 : rr == 4'h5 ? 3'h1 : 3'h0;
	endfunction
	// Watchdog against a hung handshake or conversion
	initial
	begin
		#100000;
		err_total++;
		summarize;
	end
	initial
	begin
		{hsel, hwrite, haddr, htrans, hwdata, hresetn, lux} = '0;
		hsize = 3'h2;
		q = $urandom(32'hAB40C96D);
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(8'h04, 0, 0);
		chk(q, 32'h0000C800);
		xfer(8'h00, 0, 0);
		chk(q, 0);
		// Every legal range code, reserved ones never written
		for (r = 0; r < 13; r++)
		begin
			t = $urandom >> ($urandom % 16);
			lux <= t[31:8];
			ct = t[0];
			xfer(8'h0C, 1, r % 2);
			xfer(8'h04, 1, {r[3:0], ct, 11'h200});
			xfer(8'h04, 0, 0);
			chk(q[15:9], {r[3:0], ct, 2'h1});
			if (r < 12)
				chk(resolution_loss, loss_of(r, ct));
			// Auto steps may drop busy briefly, so wait for a quiet spell
			n = 2;
			do
			begin
				while (conv_busy !== 1'b0)
				begin
					@(posedge hclk);
					n++;
				end
				repeat (3) @(posedge hclk);
				n += 3;
			end
			while (conv_busy !== 1'b0);
			if (r < 12)
				chk(n > (ct ? 160 : 20) && n < (ct ? 168 : 28), 1);
			res = expect_res(lux, r);
			chk(irq, r % 2);
			xfer(8'h04, 0, 0);
			chk(q[15:7], {r[3:0], ct, 2'h0, (lux >> res[15:12]) > 24'hFFF, 1'b1});
			xfer(8'h04, 0, 0);
			chk(q[7], 0);
			xfer(8'h00, 0, 0);
			chk(q, res);
			xfer(8'h08, 0, 0);
			chk(q[0], 1);
			chk(q[1], (lux >> res[15:12]) > 24'hFFF);
			xfer(8'h10, 0, 0);
			chk(q, 0);
			chk(irq, 0);
		end
		// Both continuous codes run until a shutdown write
		lux <= 0;
		for (m = 2; m < 4; m++)
		begin
			xfer(8'h04, 1, {4'h3, 1'b0, m[1:0], 9'h0});
			repeat (30) @(posedge hclk);
			xfer(8'h04, 0, 0);
			chk(q[10:7], {m[1:0], 2'h1});
			repeat (30) @(posedge hclk);
			xfer(8'h04, 1, 32'h3000);
			repeat (4) @(posedge hclk);
			chk(conv_busy, 0);
			xfer(8'h04, 0, 0);
			chk(q[10:7], 4'h1);
			repeat (40) @(posedge hclk);
			xfer(8'h04, 0, 0);
			chk(q[7], 0);
		end
		summarize;
	end
endmodule
`default_nettype wire
